// ---- core/pfar_sequencer.sv ----
// power-fail detection and auto-restart sequencer
//
// Summary of operation
// R1: while power line is low, hold everything in initialization before processing.
// R2: release of the power-fail line starts a 70 ms initialization pulse.
// R3: at pulse end, guard starts only with warning released; then vector load unless halted.
// R4: guard pulse lasts 2 ms; warning assertions are ignored meanwhile.
// R5: after guard, warning starts power-down timer and sets flag, resampled once more.
// R6: synchronized request is offered only at the service branch strobe.
// R7: power-fail trap pushes status word and counter, then loads vectors 24 and 26.
// R8: restart loads counter from 24 and status from 26, no stack push.
// R9: after restart load run, or halt if switch pressed and console lock clear.
// R10: warning without power-fail line restarts when power-down timer expires.
// R11: supplies release the power-fail line before the warning line at power-up.
// R12: supplies assert warning first, power-fail line more than 7 ms later.
// R13: at least 2 ms run time remain after trap before power-fail line asserts.
// R14: all intervals are counters on the processor clock, lengths derived from rate.
// R15: power-down flag and its synchronized copy are cleared during initialization.
module pfar_sequencer
  import pfar_pkg::*;
#(
  parameter int INIT_LEN = pfar_pkg::INIT_CYCLES,
  parameter int GUARD_LEN = pfar_pkg::GUARD_CYCLES,
  parameter int POWER_DOWN_TIMER_LEN = pfar_pkg::POWER_DOWN_TIMER_CYCLES
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // power status lines
  input wire logic ac_power_warning_n_i,
  input wire logic dc_power_fail_n_i,
  // console
  input wire logic halt_switch_i,
  input wire logic console_lock_i,
  // microprogram
  input wire logic service_branch_strobe_i,
  input wire logic seq_ack_i,
  output logic seq_req_o,
  output pfar_pkg::pfar_op_t seq_op_o,
  output logic [pfar_pkg::ADDR_W-1:0] seq_addr_o,
  output logic power_fail_trap_o,
  // status
  output logic init_pulse_o,
  output logic power_up_guard_pulse_o,
  output logic power_down_timer_o,
  output logic power_down_request_sync_o,
  output logic run_o,
  output logic halted_o
);
  import pfar_pkg::*;

  // ****************************************
  // parameter check
  // ****************************************
  if (INIT_LEN < 2 || GUARD_LEN < 2 || POWER_DOWN_TIMER_LEN < 2 ||
      INIT_LEN >= 2**TMR_W || GUARD_LEN >= 2**TMR_W || POWER_DOWN_TIMER_LEN >= 2**TMR_W) begin : g_chk
    $error("pfar_sequencer: interval length out of range");
  end

  // ****************************************
  // declarations
  // ****************************************
  pfar_state_t st_q, st_d;
  logic pd_flag_q, pd_flag_d;
  logic pd_sync_q, pd_sync_d;
  logic restart_q, restart_d;
  logic init_done, guard_busy, power_down_timer_busy, power_down_timer_done;
  logic init_q, run_q, halted_q, req_q, trap_q;
  pfar_op_t op_q, op_d;
  logic [ADDR_W-1:0] addr_q, addr_d;

  // ****************************************
  // decode
  // ****************************************
  wire ac_asserted = !ac_power_warning_n_i;
  wire dc_asserted = !dc_power_fail_n_i;
  wire halt_eff = halt_switch_i && !console_lock_i;
  wire in_off = (st_q == S_OFF);
  wire in_init = (st_q == S_INIT);
  wire in_acwait = (st_q == S_ACWAIT);
  wire in_run = (st_q == S_RUN);
  wire powered = !(in_off || in_init || in_acwait);
  wire restart_go = power_down_timer_done && !dc_asserted;
  wire power_up_go = ((in_init && init_done) || in_acwait) && !ac_asserted
                     && !dc_asserted && !restart_go;
  wire init_start = (st_d == S_INIT) && !in_init;
  wire pd_fire = ac_asserted && powered && !guard_busy && !power_down_timer_busy && !pd_flag_q;
  wire trap_take = in_run && service_branch_strobe_i && pd_sync_q;
  wire flag_clr = in_init || in_off || trap_take;
  wire seq_st_d = (st_d == S_PUSH_PSW) || (st_d == S_PUSH_PC) ||
                  (st_d == S_LD_PC) || (st_d == S_LD_PSW);
  pfar_state_t up_st;
  assign up_st = halt_eff ? S_HALT : S_LD_PC; // [R3]

  // ****************************************
  // interval timers
  // ****************************************
  pfar_timer #(.W(TMR_W)) u_init_tmr ( // [R2] [R14]
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .start_i(init_start),
    .clr_i(!in_init),
    .len_i(TMR_W'(INIT_LEN)),
    .busy_o(),
    .done_o(init_done)
  );

  pfar_timer #(.W(TMR_W)) u_guard_tmr ( // [R4] [R14]
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .start_i(power_up_go),
    .clr_i(in_off),
    .len_i(TMR_W'(GUARD_LEN)),
    .busy_o(guard_busy),
    .done_o()
  );

  pfar_timer #(.W(TMR_W)) u_power_down_timer_tmr ( // [R5] [R14]
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .start_i(pd_fire),
    .clr_i(in_off),
    .len_i(TMR_W'(POWER_DOWN_TIMER_LEN)),
    .busy_o(power_down_timer_busy),
    .done_o(power_down_timer_done)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_d = st_q;
    if (dc_asserted) begin
      st_d = S_OFF; // [R1]
    end else if (restart_go) begin
      st_d = S_INIT; // [R10]
    end else begin
      unique case (st_q)
        S_OFF: st_d = S_INIT; // [R2]
        S_INIT: if (init_done) st_d = ac_asserted ? S_ACWAIT : up_st; // [R3]
        S_ACWAIT: if (!ac_asserted) st_d = up_st;
        S_PUSH_PSW: if (seq_ack_i) st_d = S_PUSH_PC; // [R7]
        S_PUSH_PC: if (seq_ack_i) st_d = S_LD_PC;
        S_LD_PC: if (seq_ack_i) st_d = S_LD_PSW; // [R7] [R8]
        S_LD_PSW: if (seq_ack_i) st_d = (restart_q && halt_eff) ? S_HALT : S_RUN; // [R9]
        S_RUN: if (trap_take) st_d = S_PUSH_PSW; // [R6]
        S_HALT: if (!halt_eff) st_d = S_RUN;
        default: st_d = S_OFF;
      endcase
    end
  end

  // ****************************************
  // flags and step outputs
  // ****************************************
  assign pd_flag_d = pd_fire || (pd_flag_q && !flag_clr); // [R5] [R15]
  assign pd_sync_d = pd_flag_q && !in_init && !in_off; // [R5] [R15]
  assign restart_d = power_up_go || (restart_q && !trap_take); // [R8]
  assign op_d = (st_d == S_PUSH_PSW) ? OP_PUSH_PSW :
                (st_d == S_PUSH_PC) ? OP_PUSH_PC :
                (st_d == S_LD_PSW) ? OP_LOAD_PSW : OP_LOAD_PC;
  assign addr_d = (st_d == S_LD_PC) ? VEC_PC_ADDR : // [R7] [R8]
                  (st_d == S_LD_PSW) ? VEC_PSW_ADDR : STACK_ADDR;

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      st_q <= ST_RESET;
      pd_flag_q <= 1'b0;
      pd_sync_q <= 1'b0;
      restart_q <= 1'b0;
    end else begin
      st_q <= st_d;
      pd_flag_q <= pd_flag_d;
      pd_sync_q <= pd_sync_d;
      restart_q <= restart_d;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      init_q <= 1'b1;
      run_q <= 1'b0;
      halted_q <= 1'b0;
      req_q <= 1'b0;
      trap_q <= 1'b0;
      op_q <= pfar_op_t'(OP_RESET);
      addr_q <= STACK_ADDR;
    end else begin
      init_q <= (st_d == S_OFF) || (st_d == S_INIT); // [R1]
      run_q <= (st_d == S_RUN);
      halted_q <= (st_d == S_HALT);
      req_q <= seq_st_d;
      trap_q <= trap_take; // [R6] [R13]
      op_q <= op_d;
      addr_q <= addr_d;
    end
  end

  assign init_pulse_o = init_q;
  assign run_o = run_q;
  assign halted_o = halted_q;
  assign seq_req_o = req_q;
  assign seq_op_o = op_q;
  assign seq_addr_o = addr_q;
  assign power_fail_trap_o = trap_q;
  assign power_up_guard_pulse_o = guard_busy;
  assign power_down_timer_o = power_down_timer_busy;
  assign power_down_request_sync_o = pd_sync_q;

  // ****************************************
  // checks
  // ****************************************
  logic [31:0] init_cnt_q, guard_cnt_q, power_down_timer_cnt_q;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      init_cnt_q <= '0;
      guard_cnt_q <= '0;
      power_down_timer_cnt_q <= '0;
    end else begin
      init_cnt_q <= in_init ? init_cnt_q + 32'h1 : '0;
      guard_cnt_q <= guard_busy ? guard_cnt_q + 32'h1 : '0;
      power_down_timer_cnt_q <= power_down_timer_busy ? power_down_timer_cnt_q + 32'h1 : '0;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  // ****************************************
  // power-line checks
  // ****************************************
  dc_hold_a: assert property (dc_asserted |=> init_pulse_o && !seq_req_o && !run_o) // [R1]
    else $error("power-fail line low but processor not held");
  init_excl_a: assert property (init_pulse_o |-> !run_o && !seq_req_o && !halted_o) // [R1]
    else $error("processing during initialization");
  off_release_a: assert property (in_off && !dc_asserted |=> in_init) // [R2]
    else $error("power-fail line released but no initialization");
  init_len_a: assert property (in_init && init_done |-> init_cnt_q == INIT_LEN - 1) // [R2]
    else $error("initialization pulse length wrong");
  guard_start_a: assert property (in_init && init_done && !dc_asserted && !restart_go // [R3]
    |=> (power_up_guard_pulse_o == !$past(ac_asserted)))
    else $error("guard start does not follow warning line");
  acwait_idle_a: assert property (in_acwait |-> !seq_req_o && !power_up_guard_pulse_o) // [R3]
    else $error("load started with warning asserted");
  guard_len_a: assert property ($fell(guard_busy) && !$past(in_off) // [R4]
    |-> guard_cnt_q == GUARD_LEN)
    else $error("guard pulse length wrong");
  guard_ignore_a: assert property (guard_busy |=> !$rose(pd_flag_q)) // [R4]
    else $error("warning recognised during guard");
  guard_block_a: assert property (power_up_guard_pulse_o |=> !$rose(power_down_timer_o)) // [R4]
    else $error("power-down timer fired during guard");
  sync_lag_a: assert property ($rose(pd_flag_q) && powered ##1 powered // [R5]
    |-> power_down_request_sync_o)
    else $error("request not resampled one cycle later");
  power_down_timer_len_a: assert property ($fell(power_down_timer_o) && !$past(in_off) // [R14]
    |-> power_down_timer_cnt_q == POWER_DOWN_TIMER_LEN)
    else $error("power-down interval length wrong");
  retrigger_a: assert property (power_down_timer_done && !dc_asserted |=> in_init && init_pulse_o) // [R10]
    else $error("expired power-down timer did not restart");
  init_clear_a: assert property (in_init |=> !pd_flag_q && !power_down_request_sync_o) // [R15]
    else $error("power-down flag survives initialization");

  // ****************************************
  // trap and restart checks
  // ****************************************
  trap_offer_a: assert property (power_fail_trap_o |-> $past(service_branch_strobe_i) // [R6]
    && $past(pd_sync_q) && $past(in_run))
    else $error("trap offered outside service branch");
  trap_clear_a: assert property (power_fail_trap_o |=> !power_down_request_sync_o) // [R6]
    else $error("request still pending after trap");
  trap_push_a: assert property (power_fail_trap_o && !$past(dc_asserted) // [R7]
    && !$past(restart_go) |-> seq_req_o && seq_op_o == OP_PUSH_PSW)
    else $error("trap does not start with a push");
  step_hold_a: assert property (seq_req_o && !seq_ack_i && !dc_asserted && !restart_go // [R7]
    |=> seq_req_o && $stable(seq_op_o) && $stable(seq_addr_o))
    else $error("memory step changed before acknowledge");
  push_addr_a: assert property (seq_req_o && seq_op_o inside {OP_PUSH_PSW, OP_PUSH_PC} // [R7]
    |-> seq_addr_o == STACK_ADDR)
    else $error("push not addressed through the stack");
  psw_vector_a: assert property (seq_req_o && seq_op_o == OP_LOAD_PSW // [R7]
    |-> seq_addr_o == VEC_PSW_ADDR)
    else $error("status word not loaded from its vector");
  restart_load_a: assert property ($fell(init_pulse_o) && seq_req_o // [R8]
    |-> seq_op_o == OP_LOAD_PC && seq_addr_o == VEC_PC_ADDR)
    else $error("restart does not load counter vector first");
  restart_nopush_a: assert property (restart_q && seq_req_o // [R8]
    |-> seq_op_o inside {OP_LOAD_PC, OP_LOAD_PSW})
    else $error("stack push during restart");
  halt_up_a: assert property (st_q == S_LD_PSW && seq_ack_i && restart_q && halt_eff // [R9]
    && !dc_asserted && !restart_go |=> halted_o)
    else $error("halt switch ignored at restart");
  halt_lock_a: assert property (console_lock_i |=> !halted_o) // [R9]
    else $error("halted although console locked");

  // ****************************************
  // cover points
  // ****************************************
  restart_run_c: cover property ($fell(init_pulse_o) ##[1:8] run_o);
  trap_seq_c: cover property (power_fail_trap_o ##[1:20] (st_q == S_LD_PSW && seq_ack_i));
  halt_up_c: cover property (halted_o && restart_q);
  retrigger_c: cover property (power_down_timer_done && !dc_asserted);
  lock_run_c: cover property (console_lock_i && halt_switch_i && run_o);

endmodule // pfar_sequencer

// ---- common/pfar_pkg.sv ----
// constants and types of the power-fail and auto-restart sequencer
package pfar_pkg;

  // ****************************************
  // clock and intervals
  // ****************************************
  localparam int CLK_MHZ = 20;
  localparam int INIT_TIME_US = 70000;
  localparam int GUARD_TIME_US = 2000;
  localparam int POWER_DOWN_TIMER_TIME_US = 10000;
  localparam int INIT_CYCLES = INIT_TIME_US * CLK_MHZ;
  localparam int GUARD_CYCLES = GUARD_TIME_US * CLK_MHZ;
  localparam int POWER_DOWN_TIMER_CYCLES = POWER_DOWN_TIMER_TIME_US * CLK_MHZ;
  localparam int TMR_W = 24;

  // ****************************************
  // vector locations
  // ****************************************
  localparam int ADDR_W = 16;
  localparam logic [15:0] VEC_PC_ADDR = 16'h0014;
  localparam logic [15:0] VEC_PSW_ADDR = 16'h0016;
  localparam logic [15:0] STACK_ADDR = 16'h0000;

  // ****************************************
  // memory step codes
  // ****************************************
  typedef enum logic [1:0] {
    OP_PUSH_PSW = 2'h0,
    OP_PUSH_PC = 2'h1,
    OP_LOAD_PC = 2'h2,
    OP_LOAD_PSW = 2'h3
  } pfar_op_t;

  // ****************************************
  // sequencer states
  // ****************************************
  typedef enum logic [8:0] {
    S_OFF = 9'h001,
    S_INIT = 9'h002,
    S_ACWAIT = 9'h004,
    S_PUSH_PSW = 9'h008,
    S_PUSH_PC = 9'h010,
    S_LD_PC = 9'h020,
    S_LD_PSW = 9'h040,
    S_RUN = 9'h080,
    S_HALT = 9'h100
  } pfar_state_t;

  localparam pfar_state_t ST_RESET = S_OFF;
  localparam logic [1:0] OP_RESET = 2'h0;

endpackage

// ---- core/pfar_timer.sv ----
// retriggerable down-counting interval timer
module pfar_timer #(
  parameter int W = 24
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // control
  input wire logic start_i,
  input wire logic clr_i,
  input wire logic [W-1:0] len_i,
  // status
  output logic busy_o,
  output logic done_o
);

  logic [W-1:0] cnt_q;
  logic busy_q;
  wire cnt_one = (cnt_q == {{(W-1){1'b0}}, 1'b1});

  if (W < 2) begin : g_chk
    $error("pfar_timer: width too small");
  end

  // ****************************************
  // counter
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || (clr_i && !start_i)) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
    end else if (start_i) begin
      cnt_q <= len_i;
      busy_q <= 1'b1;
    end else if (busy_q) begin
      cnt_q <= cnt_q - 1'b1;
      busy_q <= !cnt_one;
    end
  end

  assign busy_o = busy_q;
  assign done_o = busy_q && cnt_one;

endmodule // pfar_timer

// ---- testbench/pfar_supply_model.sv ----
// behavioural model of the supplies that drive the two power status lines
module pfar_supply_model #(
  parameter int AC_DLY = 5,
  parameter int DC_DLY = 50
) (
  // clock
  input wire logic clock_i,
  // commands
  input wire logic power_on_i,
  input wire logic glitch_i,
  // power status lines
  output logic ac_power_warning_n_o,
  output logic dc_power_fail_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // sequencing
  // ****************************************
  logic on_q = 1'h0;
  int cnt_q = 1000;
  always @(posedge clock_i) begin
    if (power_on_i != on_q) begin
      on_q <= power_on_i;
      cnt_q <= 0;
    end else if (cnt_q < 1000) begin
      cnt_q <= cnt_q + 1;
    end
  end
  // dc released first, ac later
  assign ac_power_warning_n_o = on_q && cnt_q >= AC_DLY && !glitch_i;
  // dc asserted well after ac, leaving run time after the trap
  assign dc_power_fail_n_o = on_q || cnt_q < DC_DLY;
endmodule // pfar_supply_model

// ---- testbench/tb.sv ----
// self-checking bench of the power-fail and auto-restart sequencer
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import pfar_pkg::*;
  localparam int IL = 20;
  localparam int GL = 8;
  localparam int PL = 40;
  logic clock_i, rst_n_i, power_on, glitch, ac_n, dc_n, halt, lock, strobe, ack;
  pfar_op_t op;
  logic [15:0] addr;
  logic req, trap, init, guard, pdt, sync, run, hlt;
  int fails = 0;
  int n_compared = 0;
  int i, n;
  // ****************************************
  // instances
  // ****************************************
  pfar_supply_model #(.AC_DLY(5), .DC_DLY(50)) supply (.clock_i(clock_i),
    .power_on_i(power_on), .glitch_i(glitch), .ac_power_warning_n_o(ac_n),
    .dc_power_fail_n_o(dc_n));
  pfar_sequencer #(.INIT_LEN(IL), .GUARD_LEN(GL), .POWER_DOWN_TIMER_LEN(PL)) DUT (.clock_i(clock_i),
    .rst_n_i(rst_n_i), .ac_power_warning_n_i(ac_n), .dc_power_fail_n_i(dc_n),
    .halt_switch_i(halt), .console_lock_i(lock), .service_branch_strobe_i(strobe),
    .seq_ack_i(ack), .seq_req_o(req), .seq_op_o(op), .seq_addr_o(addr),
    .power_fail_trap_o(trap), .init_pulse_o(init), .power_up_guard_pulse_o(guard),
    .power_down_timer_o(pdt), .power_down_request_sync_o(sync), .run_o(run),
    .halted_o(hlt));
  // ****************************************
  // helpers
  // ****************************************
  task tick;
    @(posedge clock_i);
    #1;
  endtask
  task chk_bit(input logic got, input logic exp, input string m);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task chk_word(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task step(input pfar_op_t o, input logic [15:0] a);
    for (i = 0; i < 50 && req !== 1'h1; i++) tick();
    chk_bit(req, 1'h1, "step request");
    chk_word({14'h0000, op}, {14'h0000, o}, "step code");
    chk_word(addr, a, "step address");
    @(posedge clock_i) ack <= 1'h1;
    @(posedge clock_i) ack <= 1'h0;
    #1;
  endtask
  task stop_test;
    $display("errors %0d compared %0d", fails, n_compared);
    if (fails == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task t_restart;
    @(posedge clock_i) power_on <= 1'h1;
    #1;
    n = 0;
    for (i = 0; i < 100 && init !== 1'h0; i++) begin
      tick();
      n++;
    end
    chk_bit(n >= IL + 1 && n <= IL + 4, 1'h1, "init pulse length");
    chk_bit(guard, 1'h1, "guard after init");
    @(posedge clock_i) glitch <= 1'h1;
    #1;
    for (n = 0; n < 4; n++) begin
      @(posedge clock_i) glitch <= (n == 0);
      #1;
      chk_bit(pdt, 1'h0, "warning ignored in guard");
    end
    step(OP_LOAD_PC, VEC_PC_ADDR);
    step(OP_LOAD_PSW, VEC_PSW_ADDR);
    for (i = 0; i < 3 && run !== 1'h1; i++) tick();
    chk_bit(run, 1'h1, "run with console locked");
  endtask
  task t_trap;
    for (i = 0; i < 20 && guard !== 1'h0; i++) tick();
    @(posedge clock_i) glitch <= 1'h1;
    @(posedge clock_i) glitch <= 1'h0;
    #1;
    for (i = 0; i < 4 && sync !== 1'h1; i++) tick();
    chk_bit(pdt, 1'h1, "timer fired");
    chk_bit(sync, 1'h1, "request synchronized");
    tick();
    chk_bit(trap, 1'h0, "no trap without strobe");
    @(posedge clock_i) strobe <= 1'h1;
    @(posedge clock_i) strobe <= 1'h0;
    #1;
    chk_bit(trap, 1'h1, "trap at strobe");
    step(OP_PUSH_PSW, STACK_ADDR);
    step(OP_PUSH_PC, STACK_ADDR);
    step(OP_LOAD_PC, VEC_PC_ADDR);
    step(OP_LOAD_PSW, VEC_PSW_ADDR);
    for (i = 0; i < 3 && run !== 1'h1; i++) tick();
    chk_bit(run, 1'h1, "run after trap");
    for (i = 0; i < PL + 20 && init !== 1'h1; i++) tick();
    chk_bit(init, 1'h1, "restart on timer expiry");
    chk_bit(sync, 1'h0, "request cleared in init");
    for (i = 0; i < IL + 5 && init !== 1'h0; i++) tick();
    step(OP_LOAD_PC, VEC_PC_ADDR);
    @(posedge clock_i) lock <= 1'h0;
    #1;
    step(OP_LOAD_PSW, VEC_PSW_ADDR);
    chk_bit(hlt, 1'h1, "halted after restart load");
  endtask
  task t_halt;
    @(posedge clock_i) power_on <= 1'h0;
    #1;
    for (i = 0; i < 100 && dc_n !== 1'h0; i++) tick();
    tick();
    tick();
    chk_bit(init, 1'h1, "init held while power low");
    chk_bit(run, 1'h0, "no run while power low");
    @(posedge clock_i) begin
      lock <= 1'h0;
      power_on <= 1'h1;
    end
    for (i = 0; i < IL + 20 && hlt !== 1'h1; i++) tick();
    chk_bit(hlt, 1'h1, "halted with switch");
    chk_bit(run, 1'h0, "not running when halted");
    @(posedge clock_i) halt <= 1'h0;
    for (i = 0; i < 4 && run !== 1'h1; i++) tick();
    chk_bit(run, 1'h1, "run after halt release");
  endtask
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    clock_i = 1'h0;
    forever #25 clock_i = ~clock_i;
  end
  initial begin
    #(50 * 4000);
    fails++;
    stop_test();
  end
  initial begin
    rst_n_i = 1'h0;
    power_on = 1'h0;
    glitch = 1'h0;
    halt = 1'h1;
    lock = 1'h1;
    strobe = 1'h0;
    ack = 1'h0;
    repeat (8) @(posedge clock_i);
    rst_n_i <= 1'h1;
    #1;
    t_restart();
    t_trap();
    t_halt();
    stop_test();
  end
endmodule // tb
